// [testbench/dbf_framer_test.sv]
// dbf_framer_test: self-checking bench for the frame assembler
// assumes a single AHB-Lite slave whose hreadyout is the bus ready
`timescale 1ns/100ps
`default_nettype none
module dbf_framer_test;
   import dbf_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0; // clock and reset
   logic hsel = 1'b0, hwrite = 1'b0; // bus request
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata, r;
   logic hreadyout, hresp, smp_valid = 1'b0, smp_ready, lane_strobe, frame_start, rx_valid;
   logic fmt4 = 1'b0, go = 1'b0, slow = 1'b0; // receiver setup
   dbf_sample_t smp_data = '0, rx_smp;
   dbf_lanes_t lane_data;
   logic [7:0] lane_active, pll_mult;
   logic [1:0] sel_a, sel_b, sel_c;
   int err_count = 0, n_compared = 0, cyc = 0;
   dbf_sample_t exp_q[$], got_q[$]; // sent and recovered sample sets
   always #10 hclk = ~hclk;
   dbf_framer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .smp_valid(smp_valid),
      .smp_ready(smp_ready), .smp_data(smp_data), .lane_strobe(lane_strobe),
      .lane_data(lane_data), .lane_active(lane_active), .frame_start(frame_start),
      .frame_format_select_a(sel_a), .frame_format_select_b(sel_b),
      .frame_format_select_c(sel_c), .pll_mult(pll_mult));
   dbf_rx_model u_rx (.hclk(hclk), .hresetn(hresetn), .fmt4(fmt4), .go(go), .slow(slow),
      .lane_strobe(lane_strobe), .lane_data(lane_data), .frame_start(frame_start),
      .rx_smp(rx_smp), .rx_valid(rx_valid));
   // collect recovered sets; cut a hang short
   always @(posedge hclk) begin
      if (rx_valid) got_q.push_back(rx_smp);
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         close_out();
      end
   end
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [127:0] e, input logic [127:0] g);
      n_compared++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", what, e, g);
         err_count++;
      end
   endtask
   // one single word transfer; read data is caught while it stands
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
      end while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   function automatic logic [31:0] ctl(int dec, bit en, bit f4);
      return (32'(dec) << 8) | (32'(en) << 1) | 32'(f4);
   endfunction
   // sample set k: high byte names the field, low byte the set
   function automatic dbf_sample_t mk(int k);
      logic [127:0] s;
      for (int j = 0; j < 8; j++) s[127-16*j -: 16] = {4'(j), 4'hA, 8'(k)};
      return s;
   endfunction
   // offer one set; ok stays 0 if it is refused for several cycles
   task automatic push(input dbf_sample_t v, output bit ok);
      smp_valid <= 1'b1;
      smp_data <= v;
      ok = 0;
      for (int t = 0; t < 6 && !ok; t++) begin
         @(posedge hclk);
         ok = smp_ready;
      end
      smp_valid <= 1'b0;
      // let one edge pass so the next offer does not reassign valid in this step
      @(posedge hclk);
      if (ok) exp_q.push_back(v);
   endtask
   task automatic drain_check(input int n);
      for (int t = 0; t < 600 && got_q.size() < n; t++) @(posedge hclk);
      chk("sets recovered", 128'(n), 128'(got_q.size()));
      while (got_q.size() > 0 && exp_q.size() > 0) chk("sample set", exp_q.pop_front(), got_q.pop_front());
   endtask
   // reset values on ports and registers
   task automatic t_reset();
      xfer(DBF_CTRL_OFS, 1'b0, 32'h0);
      chk("ctrl reset", 128'(DBF_CTRL_RST), 128'(r));
      chk("select ports", {DBF_SEL_A_8L, DBF_SEL_BC, DBF_SEL_BC, DBF_PLL_8L}, {sel_a, sel_b, sel_c, pll_mult});
      chk("lanes idle", 128'h0, 128'(lane_data));
      xfer(8'h40, 1'b0, 32'h0);
      chk("unmapped read", 128'h0, 128'(r));
   endtask
   // every decimation in both formats: legality, select fields, rate
   task automatic t_formats();
      int decs[10] = '{8, 9, 10, 12, 16, 18, 20, 24, 32, 11};
      logic [7:0] pll;
      bit legal;
      for (int f = 0; f < 2; f++) for (int i = 0; i < 10; i++) begin
         xfer(DBF_CTRL_OFS, 1'b1, ctl(decs[i], 0, f[0]));
         xfer(DBF_STAT_OFS, 1'b1, 32'hFFFF_FFFF);
         xfer(DBF_STAT_OFS, 1'b0, 32'h0);
         pll = f ? DBF_PLL_4L : DBF_PLL_8L;
         legal = i < 9 && (f == 1 || i < 7);
         chk("status", {pll, pll, 8'h00, legal, f[0], 4'h0, f ? DBF_SEL_A_4L : DBF_SEL_A_8L},
            128'(r & 32'hFFFF_00FF));
         chk("pll port", 128'(pll), 128'(pll_mult));
         chk("active lanes", f ? 8'h66 : 8'hFF, 128'(lane_active));
      end
   endtask
   // stream four sets back to back and compare what the receiver rebuilds
   task automatic t_stream(input bit f4, input bit sl);
      logic [31:0] c0;
      bit ok;
      fmt4 <= f4;
      slow <= sl;
      go <= 1'b1;
      xfer(DBF_CNT_OFS, 1'b0, 32'h0);
      c0 = r;
      xfer(DBF_CTRL_OFS, 1'b1, ctl(8, 1, f4));
      for (int k = 0; k < 4; k++) push(mk(k + 16 * f4), ok);
      drain_check(4);
      xfer(DBF_CNT_OFS, 1'b0, 32'h0);
      chk("frame count", 128'(c0 + 4), 128'(r));
      chk("lanes idle after", 128'h0, 128'(lane_data));
   endtask
   // blocked output fills the buffer; a legal setting then drains it slowly
   task automatic t_fill();
      int n = 0;
      bit ok = 1;
      fmt4 <= 1'b1;
      slow <= 1'b1;
      xfer(DBF_CTRL_OFS, 1'b1, ctl(32, 1, 0));
      while (ok && n < 40) begin
         push(mk(n + 64), ok);
         n += ok;
      end
      chk("sets held", 128'd33, 128'(n));
      chk("nothing sent", 128'(0), 128'(got_q.size()));
      xfer(DBF_CTRL_OFS, 1'b1, ctl(32, 1, 1));
      drain_check(33);
   endtask
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_formats();
      t_stream(0, 0);
      t_stream(1, 1);
      t_fill();
      close_out();
   end
endmodule // dbf_framer_test
`default_nettype wire

// [testbench/dbf_rx_model.sv]
// dbf_rx_model: behavioural lane receiver facing the frame assembler
// assumes each strobe it issues is answered with fresh octets one cycle later
`timescale 1ns/100ps
`default_nettype none
module dbf_rx_model
   import dbf_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // link setup, must match the transmitter
   input wire logic fmt4,
   input wire logic go,
   input wire logic slow,
   // lane side
   output logic lane_strobe,
   input wire dbf_lanes_t lane_data,
   input wire logic frame_start,
   // recovered samples
   output dbf_sample_t rx_smp,
   output logic rx_valid
);
   logic [31:0] sh [8]; // octet history of each lane
   logic tog; // pacing toggle for the slow mode
   logic std; // strobe delayed to the cycle its octets stand
   int idx; // octet index in the frame, 0 while hunting
   // pacing and de-mapping; slow mode stalls by strobing every other cycle
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lane_strobe <= 1'b0;
         tog <= 1'b0;
         std <= 1'b0;
         rx_valid <= 1'b0;
         rx_smp <= '0;
         idx = 0;
      end else begin
         tog <= ~tog;
         lane_strobe <= go & (~slow | tog);
         std <= lane_strobe;
         rx_valid <= 1'b0;
         // octets outside a frame are dropped until the next frame marker
         if (std && (frame_start || idx > 0)) begin
            for (int i = 0; i < 8; i++) sh[i] = {sh[i][23:0], lane_data[63-8*i -: 8]};
            idx = frame_start ? 1 : idx + 1;
            if (idx == (fmt4 ? 4 : 2)) begin
               idx = 0;
               rx_valid <= 1'b1;
               if (fmt4) rx_smp <= {sh[1], sh[2], sh[5], sh[6]};
               else rx_smp <= {sh[0][15:0], sh[1][15:0], sh[2][15:0], sh[3][15:0],
                  sh[4][15:0], sh[5][15:0], sh[6][15:0], sh[7][15:0]};
            end
         end
      end
   end
endmodule // dbf_rx_model
`default_nettype wire

// [verilog/dbf_fifo.sv]
// dbf_fifo: synchronous valid/ready FIFO with registered read data
// assumes one clock; width and depth are parameters, depth a power of two
`timescale 1ns/100ps
`default_nettype none
module dbf_fifo #(
   parameter int WIDTH = 128,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
      logic ov; // read register holds a word
   } dbf_fifo_st_t;
   dbf_fifo_st_t st, next_st;
   logic [WIDTH-1:0] mem [DEPTH]; // storage
   logic [WIDTH-1:0] rd; // registered read data
   logic empty, full, push, pop, load;
   // full and empty from pointer compare
   always_comb begin
      empty = (st.wp == st.rp);
      full = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
      in_ready = !full;
      push = in_valid && !full;
      pop = out_valid && out_ready;
      load = !empty && (!st.ov || pop); // refill output register
      out_valid = st.ov;
      out_data = rd;
      next_st = st;
      if (push) begin
         next_st.wp = st.wp + 1'b1;
      end
      if (load) begin
         next_st.rp = st.rp + 1'b1;
         next_st.ov = 1'b1;
      end else if (pop) begin
         next_st.ov = 1'b0;
      end
   end
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // memory has no reset; read data register keeps it out of the output path
   always_ff @(posedge hclk) begin
      if (push) begin
         mem[st.wp[AW-1:0]] <= in_data;
      end
      if (load) begin
         rd <= mem[st.rp[AW-1:0]];
      end
   end
   no_overflow_a: assert property (@(posedge hclk) disable iff (!hresetn)
      full |-> !push) else $error("fifo written while full");
endmodule // dbf_fifo
`default_nettype wire

// [verilog/dbf_framer.sv]
// dbf_framer: dual-band complex frame assembly onto two four-lane groups
// assumes samples arrive on a valid/ready port at one set per decimated period,
// and a link layer downstream takes one octet per lane on each lane_strobe.
//
// Behaviour
// - two formats: eight-lane 20X, four-lane 40X
// - decimation 24 and 32 allow four-lane only
// - lane rate is clock times 20 (eight-lane) or 40 (four-lane) over decimation
// - two bands per channel, eight converters
// - eight-lane: one sample per lane, high byte first
// - four-lane: lanes 1,2 carry I then Q
// - channel A bands stay on A lanes
// - channel B bands stay on B lanes
//
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module dbf_framer
   import dbf_pkg::*;
#(
   parameter int FIFO_DEPTH = 32
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // sample input from down-converter bands
   input wire logic smp_valid,
   output logic smp_ready,
   input wire dbf_sample_t smp_data,
   // lane octet output
   input wire logic lane_strobe,
   output dbf_lanes_t lane_data,
   output logic [7:0] lane_active,
   output logic frame_start,
   // format selection as seen by the link layer
   output logic [1:0] frame_format_select_a,
   output logic [1:0] frame_format_select_b,
   output logic [1:0] frame_format_select_c,
   output logic [7:0] pll_mult
);
   // whole module state
   typedef struct packed {
      logic [31:0] ctrl; // software control word
      logic fmt4; // applied format, 1 four-lane
      logic [5:0] dec; // applied decimation
      logic dec_ok; // applied decimation is legal
      logic dph; // write data phase pending
      logic rph; // read data phase pending
      logic [7:0] addr; // latched address
      logic [31:0] rdat; // read data
      logic [1:0] oct; // octet position in frame
      logic busy; // a frame is in flight
      dbf_sample_t cur; // sample being sent
      dbf_lanes_t lanes; // output octets
      logic fs; // first octet marker
      logic [31:0] frames; // frames sent
   } dbf_st_t;
   dbf_st_t st, next_st;
   // fifo drain side
   logic f_valid, f_ready;
   dbf_sample_t f_data;
   // decoded request helpers
   logic req_fmt4, legal, take, last_oct, req_ok;
   logic [5:0] req_dec;
   logic [7:0] rate_num;
   // sample buffer; back-pressure reaches the source through smp_ready
   dbf_fifo #(
      .WIDTH($bits(dbf_sample_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .hclk(hclk),
      .hresetn(hresetn),
      .in_valid(smp_valid),
      .in_ready(smp_ready),
      .in_data(smp_data),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );
   // legal decimation check
   function automatic logic dec_legal(input logic [5:0] d, input logic f4);
      case (d)
         6'h08, 6'h09, 6'h0A, 6'h0C, 6'h10, 6'h12, 6'h14: dec_legal = 1'b1;
         6'h18, 6'h20: dec_legal = f4;
         default: dec_legal = 1'b0;
      endcase
   endfunction
   // octet mapping for one frame position
   function automatic dbf_lanes_t map_oct(input dbf_sample_t s, input logic f4,
                                          input logic [1:0] o);
      dbf_lanes_t l;
      l = '0;
      if (!f4) begin
         // one sample per lane, high byte at octet 0
         l.a0 = o[0] ? s.a1i[7:0] : s.a1i[15:8];
         l.a1 = o[0] ? s.a1q[7:0] : s.a1q[15:8];
         l.a2 = o[0] ? s.a2i[7:0] : s.a2i[15:8];
         l.a3 = o[0] ? s.a2q[7:0] : s.a2q[15:8];
         l.b0 = o[0] ? s.b1i[7:0] : s.b1i[15:8];
         l.b1 = o[0] ? s.b1q[7:0] : s.b1q[15:8];
         l.b2 = o[0] ? s.b2i[7:0] : s.b2i[15:8];
         l.b3 = o[0] ? s.b2q[7:0] : s.b2q[15:8];
      end else begin
         // lanes 1 and 2 only: I high, I low, Q high, Q low
         case (o)
            2'h0: begin
               l.a1 = s.a1i[15:8];
               l.a2 = s.a2i[15:8];
               l.b1 = s.b1i[15:8];
               l.b2 = s.b2i[15:8];
            end
            2'h1: begin
               l.a1 = s.a1i[7:0];
               l.a2 = s.a2i[7:0];
               l.b1 = s.b1i[7:0];
               l.b2 = s.b2i[7:0];
            end
            2'h2: begin
               l.a1 = s.a1q[15:8];
               l.a2 = s.a2q[15:8];
               l.b1 = s.b1q[15:8];
               l.b2 = s.b2q[15:8];
            end
            default: begin
               l.a1 = s.a1q[7:0];
               l.a2 = s.a2q[7:0];
               l.b1 = s.b1q[7:0];
               l.b2 = s.b2q[7:0];
            end
         endcase
      end
      map_oct = l;
   endfunction
   // next-state logic
   always_comb begin
      next_st = st;
      req_fmt4 = st.ctrl[DBF_FMT_BIT];
      req_dec = st.ctrl[DBF_DEC_LSB +: 6];
      req_ok = dec_legal(req_dec, req_fmt4);
      legal = st.ctrl[DBF_EN_BIT] && st.dec_ok;
      last_oct = st.fmt4 ? (st.oct == 2'h3) : (st.oct == 2'h1);
      take = lane_strobe && legal && (!st.busy || last_oct) && f_valid;
      f_ready = take;
      // bus: address phase
      if (hsel && hready && htrans[1]) begin
         next_st.addr = haddr;
         next_st.dph = hwrite;
         next_st.rph = !hwrite;
      end else if (hready) begin
         next_st.dph = 1'b0;
         next_st.rph = 1'b0;
      end
      // bus: write data phase; unmapped and read-only offsets ignore writes
      if (st.dph && st.addr == DBF_CTRL_OFS) begin
         next_st.ctrl = hwdata;
      end
      // format applied only between frames so a frame never mixes layouts;
      // a frame launched this cycle was mapped with the old format, so hold it
      if (!st.busy && !take) begin
         next_st.fmt4 = req_fmt4;
         next_st.dec = req_dec;
         next_st.dec_ok = req_ok;
      end
      // octet sequencer, advanced once per lane clock enable
      next_st.fs = 1'b0;
      if (lane_strobe) begin
         if (take) begin
            next_st.cur = f_data;
            next_st.busy = 1'b1;
            next_st.oct = 2'h0;
            next_st.lanes = map_oct(f_data, st.fmt4, 2'h0);
            next_st.fs = 1'b1;
            next_st.frames = st.frames + 32'h0000_0001;
         end else if (st.busy && !last_oct) begin
            next_st.oct = st.oct + 2'h1;
            next_st.lanes = map_oct(st.cur, st.fmt4, st.oct + 2'h1);
         end else begin
            next_st.busy = 1'b0;
            next_st.lanes = '0;
         end
      end
      // read mux, registered for the data phase
      next_st.rdat = 32'h0000_0000;
      if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr)
            DBF_CTRL_OFS: next_st.rdat = st.ctrl;
            DBF_STAT_OFS: next_st.rdat = {rate_num, pll_mult, 7'h00, st.busy, st.dec_ok,
                                          st.fmt4, frame_format_select_c,
                                          frame_format_select_b, frame_format_select_a};
            DBF_CNT_OFS: next_st.rdat = st.frames;
            default: next_st.rdat = 32'h0000_0000; // unmapped reads zero
         endcase
      end
   end
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '{ctrl: DBF_CTRL_RST, default: '0};
      end else begin
         st <= next_st;
      end
   end
   // outputs
   always_comb begin
      hreadyout = 1'b1; // zero wait states
      hresp = 1'b0;
      hrdata = st.rdat;
      lane_data = st.lanes;
      frame_start = st.fs;
      // format select fields: 1 eight-lane, 2 four-lane, others 0
      frame_format_select_a = st.fmt4 ? DBF_SEL_A_4L : DBF_SEL_A_8L;
      frame_format_select_b = DBF_SEL_BC;
      frame_format_select_c = DBF_SEL_BC;
      pll_mult = st.fmt4 ? DBF_PLL_4L : DBF_PLL_8L;
      // lane rate over sample clock, in units of 1/dec: 20 or 40
      rate_num = pll_mult;
      lane_active = st.fmt4 ? 8'h66 : 8'hFF;
   end
   // assertions
   idle_lanes_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st.fmt4 && st.busy |-> lane_data.a0 == 8'h00 && lane_data.b3 == 8'h00)
      else $error("unused lane driven in four-lane format");
   sel_fields_a: assert property (@(posedge hclk) disable iff (!hresetn)
      frame_format_select_a == (st.fmt4 ? 2'h2 : 2'h1) && frame_format_select_b == 2'h0
      && frame_format_select_c == 2'h0) else $error("format select mismatch");
   pll_mult_a: assert property (@(posedge hclk) disable iff (!hresetn)
      pll_mult == (st.fmt4 ? 8'd40 : 8'd20)) else $error("multiplier mismatch");
   dec_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (st.dec == 6'd24 || st.dec == 6'd32) && !st.fmt4 |-> !st.dec_ok)
      else $error("eight-lane allowed at 24 or 32");
   no_send_bad_a: assert property (@(posedge hclk) disable iff (!hresetn)
      f_ready |-> st.dec_ok && st.ctrl[DBF_EN_BIT]) else $error("frame on illegal setting");
   hi_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
      take && !st.fmt4 |=> lane_data.a0 == $past(f_data.a1i[15:8])
      && lane_data.b2 == $past(f_data.b2i[15:8])) else $error("high byte not first");
   four_q_a: assert property (@(posedge hclk) disable iff (!hresetn)
      st.busy && st.fmt4 && st.oct == 2'h2 |-> lane_data.a1 == st.cur.a1q[15:8]
      && lane_data.b2 == st.cur.b2q[15:8]) else $error("Q octet misplaced");
   converters_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $countones(lane_active) == (st.fmt4 ? 4 : DBF_CONV)) else $error("lane count wrong");
   ok_resp_a: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp) else $error("bus response not okay");
   eight_c: cover property (@(posedge hclk) disable iff (!hresetn) take && !st.fmt4);
   four_c: cover property (@(posedge hclk) disable iff (!hresetn) take && st.fmt4);
   full_c: cover property (@(posedge hclk) disable iff (!hresetn) !smp_ready);
endmodule // dbf_framer
`default_nettype wire

// [verilog/dbf_pkg.sv]
// dbf_pkg: constants and carrier types for the dual-band complex frame assembler
// assumes a 32-bit AHB-Lite register port and 16-bit I/Q samples from two bands per channel
package dbf_pkg;
   // register byte offsets
   localparam logic [7:0] DBF_CTRL_OFS = 8'h00; // format request and decimation
   localparam logic [7:0] DBF_STAT_OFS = 8'h04; // applied format, select fields, rate
   localparam logic [7:0] DBF_CNT_OFS = 8'h08; // frames sent
   // control fields
   localparam int DBF_FMT_BIT = 0; // 0 eight-lane, 1 four-lane
   localparam int DBF_EN_BIT = 1; // assembly enable
   localparam int DBF_DEC_LSB = 8; // decimation factor, 6 bits
   localparam logic [31:0] DBF_CTRL_RST = 32'h0000_0800; // decimation 8, eight-lane, off
   // select field values per format
   localparam logic [1:0] DBF_SEL_A_8L = 2'h1;
   localparam logic [1:0] DBF_SEL_A_4L = 2'h2;
   localparam logic [1:0] DBF_SEL_BC = 2'h0;
   localparam logic [7:0] DBF_PLL_8L = 8'h14; // 20X serializer multiplier
   localparam logic [7:0] DBF_PLL_4L = 8'h28; // 40X serializer multiplier
   // octets per frame per active lane
   localparam logic [1:0] DBF_OCT_8L = 2'h2;
   localparam logic [1:0] DBF_OCT_4L = 2'h0; // 4 octets, wraps in 2 bits
   localparam int DBF_LANES = 8;
   localparam int DBF_CONV = 8; // complex components across both channels
   // one sample set: two channels, two bands, I and Q
   typedef struct packed {
      logic [15:0] a1i, a1q, a2i, a2q;
      logic [15:0] b1i, b1q, b2i, b2q;
   } dbf_sample_t;
   // lane octets
   typedef struct packed {
      logic [7:0] a0, a1, a2, a3;
      logic [7:0] b0, b1, b2, b3;
   } dbf_lanes_t;
endpackage
